// ---- design/ecp_parallel_port.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Reverse: host-ack low requests a byte
// - Forward: host-ack marks address or data
// - Host-ack interlocks with peripheral acknowledge strobe
// - Reverse request is a hint only
// - Request honoured only in forward direction
// - Init low reverse, high forward
// - Select-in stays deasserted in ECP mode
// - Three-bit mode field selects port mode
// - Mode 100 is EPP only when enabled
// - Register decode depends on mode
// - Offsets are added to the base
// - Decode qualified by address enable
// - Extended registers sit above standard ones
// - Works as a standard parallel port
module ecp_parallel_port (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ecp_port_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic                            aen,
  output logic                                 pready,
  output logic      [31:0]                     prdata,
  output logic                                 pslverr,
  input  wire logic [7:0]                      pdata_in,
  output logic      [7:0]                      pdata_out,
  output logic                                 pdata_oe_n,
  output logic                                 strobe_n,
  output logic                                 host_ack_out,
  output logic                                 direction_init_out,
  output logic                                 select_in_out,
  input  wire logic                            peripheral_ack_strobe,
  input  wire logic                            peripheral_flow_ack,
  input  wire logic                            reverse_ack,
  input  wire logic                            online_in,
  input  wire logic                            fault_in
);
  import ecp_port_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0]  port_data;
  logic [5:0]  line_control;
  logic [5:0]  ext_ctrl;
  logic [11:0] base_index;
  logic        epp_enable;
  logic        periph_req;
  logic [7:0]  hold_byte;
  logic        hold_full;
  logic        hold_addr;
  logic        fault_prev;
  state_t      state;
  state_t      next_state;

  logic [2:0]  mode;
  logic        dir_bit;
  logic        is_ecp;
  logic        fifo_mode;
  logic        std_mode;
  logic        rev_side;
  logic [11:0] index;
  logic [11:0] rel;
  logic        sel;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [7:0]  next_rbyte;
  logic        hit_data;
  logic        hit_status;
  logic        hit_control;
  logic        hit_fifo;
  logic        hit_configb;
  logic        hit_extctrl;
  logic        hit_setup;
  logic        bus_push;
  logic        bus_push_addr;
  logic        bus_pop;
  logic        link_push;
  logic        link_pop;
  logic        preq_event;
  logic        preq_clear;
  logic [7:0]  next_pdata;
  logic        next_oe_n;
  logic        next_strobe_n;
  logic        next_host_ack;
  logic        next_init;
  logic        next_selin;

  assign mode      = ext_ctrl[EXT_MODE-EXT_LOW +: 3];
  assign dir_bit   = line_control[CTL_DIR];
  assign is_ecp    = (mode == MODE_ECP);
  assign fifo_mode = is_ecp || (mode == MODE_COMPAT);
  // Mode 100 without EPP enabled falls back to bidirectional use
  assign std_mode  = (mode == MODE_STD) || (mode == MODE_BIDIR) ||
                     ((mode == MODE_EPP) && !epp_enable);
  assign rev_side  = (state == st_rev_turn) || (state == st_rev_request) ||
                     (state == st_rev_hold);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign index = paddr[ADDR_W-1:2];
  assign rel   = index - base_index;
  assign sel   = psel && !aen;
  assign acc   = psel && penable && pready;
  assign wr    = acc && pwrite && mapped;
  assign rd    = acc && !pwrite && mapped;

  always_comb begin
    hit_data    = sel && (rel == IDX_DATA) && (std_mode || is_ecp);
    hit_status  = sel && (rel == IDX_STATUS);
    hit_control = sel && (rel == IDX_CONTROL);
    // Upper-bit decode keeps these clear of the standard port window
    hit_fifo    = sel && (rel == IDX_FIFO) &&
                  (fifo_mode || (mode == MODE_TEST) ||
                   (mode == MODE_CONFIG));
    hit_configb = sel && (rel == IDX_CONFIGB) && (mode == MODE_CONFIG);
    hit_extctrl = sel && (rel == IDX_EXTCTRL);
    hit_setup   = sel && (index == IDX_SETUP);
    // Anything else answers with an error, never a silent hit
    mapped      = hit_data || hit_status || hit_control || hit_fifo ||
                  hit_configb || hit_extctrl || hit_setup;
  end

  always_comb begin
    next_rbyte = 8'h00;
    if (hit_data && is_ecp) begin
      next_rbyte = hold_byte;
    end else if (hit_data) begin
      next_rbyte = (dir_bit && mode != MODE_STD) ? pdata_in : port_data;
    end else if (hit_status) begin
      next_rbyte = {!peripheral_flow_ack, peripheral_ack_strobe, reverse_ack,
                    online_in, fault_in, 3'h0};
    end else if (hit_control) begin
      next_rbyte = {2'h0, line_control};
    end else if (hit_fifo && mode == MODE_CONFIG) begin
      next_rbyte = CONFIG_A_VAL;
    end else if (hit_fifo) begin
      next_rbyte = hold_byte;
    end else if (hit_configb) begin
      next_rbyte = CONFIG_B_VAL;
    end else if (hit_extctrl) begin
      next_rbyte = {ext_ctrl, hold_full, !hold_full};
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !mapped;
        if (hit_setup) begin
          prdata <= {17'h0_0000, rev_side, periph_req, epp_enable, base_index};
        end else begin
          prdata <= {24'h00_0000, next_rbyte};
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_data    <= DATA_RESET;
      line_control <= CONTROL_RESET;
      ext_ctrl     <= EXT_RESET;
      base_index   <= BASE_RESET;
      epp_enable   <= 1'b0;
    end else begin
      if (wr && hit_data && !is_ecp) begin
        port_data <= pwdata[7:0];
      end
      if (wr && hit_control) begin
        line_control <= pwdata[5:0];
      end
      if (wr && hit_extctrl) begin
        ext_ctrl <= pwdata[7:2];
      end
      if (wr && hit_setup) begin
        base_index <= pwdata[11:0];
        epp_enable <= pwdata[SET_EPP];
      end
    end
  end

  // Peripheral request is only a sticky hint; direction stays ours
  assign preq_event = is_ecp && !rev_side && (state != st_fwd_turn) &&
                      fault_prev && !fault_in;
  assign preq_clear = wr && hit_setup && pwdata[SET_PREQ];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_prev <= 1'b1;
      periph_req <= 1'b0;
    end else begin
      fault_prev <= fault_in;
      if (preq_event) begin
        periph_req <= 1'b1;
      end else if (preq_clear) begin
        periph_req <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // One-byte hold buffer
  // ------------------------------------------------------------
  assign bus_push      = wr && !hold_full && !dir_bit &&
                         ((hit_data && is_ecp) ||
                          (hit_fifo && (fifo_mode || mode == MODE_TEST)));
  assign bus_push_addr = hit_data && is_ecp;
  // Test mode re-reads the last byte when empty
  assign bus_pop       = rd && hold_full &&
                         ((hit_fifo && (is_ecp || mode == MODE_TEST)) ||
                          (hit_data && is_ecp));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_byte <= DATA_RESET;
      hold_full <= 1'b0;
      hold_addr <= 1'b0;
    end else begin
      if (link_push) begin
        hold_byte <= pdata_in;
        hold_full <= 1'b1;
        hold_addr <= 1'b0;
      end else if (bus_push) begin
        hold_byte <= pwdata[7:0];
        hold_full <= 1'b1;
        hold_addr <= bus_push_addr;
      end else if (link_pop || bus_pop) begin
        hold_full <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Link handshake
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    link_push  = 1'b0;
    link_pop   = 1'b0;
    case (state)
      st_idle: begin
        if (is_ecp && dir_bit && !hold_full) begin
          next_state = st_rev_turn;
        end else if (fifo_mode && !dir_bit && hold_full) begin
          next_state = st_fwd_setup;
        end
      end
      st_fwd_setup: begin
        next_state = st_fwd_strobe;
      end
      st_fwd_strobe: begin
        if (peripheral_flow_ack) begin
          next_state = st_fwd_release;
        end
      end
      st_fwd_release: begin
        if (!peripheral_flow_ack) begin
          link_pop   = 1'b1;
          next_state = st_idle;
        end
      end
      st_rev_turn: begin
        if (!reverse_ack) begin
          next_state = st_rev_request;
        end
      end
      st_rev_request: begin
        if (!is_ecp || !dir_bit) begin
          next_state = st_fwd_turn;
        end else if (!peripheral_ack_strobe) begin
          link_push  = 1'b1;
          next_state = st_rev_hold;
        end
      end
      st_rev_hold: begin
        if (peripheral_ack_strobe && (!is_ecp || !dir_bit)) begin
          next_state = st_fwd_turn;
        end else if (peripheral_ack_strobe && !hold_full) begin
          next_state = st_rev_request;
        end
      end
      st_fwd_turn: begin
        if (reverse_ack) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_comb begin
    next_pdata    = port_data;
    next_oe_n     = 1'b0;
    next_strobe_n = !line_control[CTL_STROBE];
    next_host_ack = !line_control[CTL_AUTOFD];
    next_init     = line_control[CTL_INIT];
    next_selin    = !line_control[CTL_SELIN];
    if (std_mode) begin
      next_oe_n = dir_bit && (mode != MODE_STD);
    end else if (mode == MODE_TEST) begin
      next_pdata = hold_byte;
    end else if (fifo_mode) begin
      next_pdata = hold_byte;
      if (state == st_fwd_strobe) begin
        next_strobe_n = 1'b0;
      end else begin
        next_strobe_n = 1'b1;
      end
      if (is_ecp) begin
        next_selin    = 1'b1;
        next_init     = !rev_side;
        next_host_ack = 1'b1;
        // Bus stays driven until the peripheral acknowledges the turn
        next_oe_n     = (state == st_rev_request) ||
                        (state == st_rev_hold) ||
                        (state == st_fwd_turn);
        if (state == st_rev_request) begin
          next_host_ack = 1'b0;
        end else if (state == st_fwd_setup || state == st_fwd_strobe ||
                     state == st_fwd_release) begin
          next_host_ack = !hold_addr;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdata_out          <= DATA_RESET;
      pdata_oe_n         <= 1'b0;
      strobe_n           <= 1'b1;
      host_ack_out       <= 1'b1;
      direction_init_out <= 1'b0;
      select_in_out      <= 1'b1;
    end else begin
      pdata_out          <= next_pdata;
      pdata_oe_n         <= next_oe_n;
      strobe_n           <= next_strobe_n;
      host_ack_out       <= next_host_ack;
      direction_init_out <= next_init;
      select_in_out      <= next_selin;
    end
  end

endmodule

// ---- design/ecp_port_pkg.sv ----
package ecp_port_pkg;

  // ------------------------------------------------------------
  // Bus and register index map (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 14;
  localparam int          IDX_W       = 12;
  localparam logic [11:0] IDX_DATA    = 12'h000;
  localparam logic [11:0] IDX_STATUS  = 12'h001;
  localparam logic [11:0] IDX_CONTROL = 12'h002;
  localparam logic [11:0] IDX_FIFO    = 12'h400;
  localparam logic [11:0] IDX_CONFIGB = 12'h401;
  localparam logic [11:0] IDX_EXTCTRL = 12'h402;
  localparam logic [11:0] IDX_SETUP   = 12'hff0;

  // ------------------------------------------------------------
  // Port modes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_STD    = 3'h0;
  localparam logic [2:0] MODE_BIDIR  = 3'h1;
  localparam logic [2:0] MODE_COMPAT = 3'h2;
  localparam logic [2:0] MODE_ECP    = 3'h3;
  localparam logic [2:0] MODE_EPP    = 3'h4;
  localparam logic [2:0] MODE_TEST   = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_DIR    = 5;
  localparam int EXT_MODE   = 5;
  localparam int EXT_LOW    = 2;
  localparam int SET_EPP    = 12;
  localparam int SET_PREQ   = 13;
  localparam int SET_DIRREV = 14;

  // ------------------------------------------------------------
  // Reset and fixed values
  // ------------------------------------------------------------
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [5:0]  CONTROL_RESET = 6'h00;
  localparam logic [5:0]  EXT_RESET     = 6'h00;
  localparam logic [11:0] BASE_RESET    = 12'h000;
  localparam logic [7:0]  CONFIG_A_VAL  = 8'h10;
  localparam logic [7:0]  CONFIG_B_VAL  = 8'h00;

  typedef enum logic [2:0] {
    st_idle,
    st_fwd_setup,
    st_fwd_strobe,
    st_fwd_release,
    st_rev_turn,
    st_rev_request,
    st_rev_hold,
    st_fwd_turn
  } state_t;

endpackage

// ---- dv/ecp_peripheral_model.sv ----
`timescale 1ns/1ps
module ecp_peripheral_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] pdata_out,
  input  wire logic       strobe_n,
  input  wire logic       host_ack_out,
  input  wire logic       direction_init_out,
  input  wire logic       select_in_out,
  output logic      [7:0] pdata_in,
  output logic            peripheral_ack_strobe,
  output logic            peripheral_flow_ack,
  output logic            reverse_ack,
  output logic            online_in,
  output logic            fault_in
);
  logic [7:0] got;
  logic [7:0] rev_byte;
  logic       tag;
  initial begin
    pdata_in = 8'h00;
    rev_byte = 8'h00;
    got = 8'h00;
    tag = 1'b0;
    online_in = 1'b1;
    fault_in = 1'b1;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      peripheral_flow_ack <= 1'b0;
      peripheral_ack_strobe <= 1'b1;
      reverse_ack <= 1'b1;
    end else begin
      reverse_ack <= direction_init_out;
      if (!strobe_n && !peripheral_flow_ack) begin
        peripheral_flow_ack <= 1'b1;
        got <= pdata_out;
        tag <= host_ack_out;
      end else if (strobe_n) begin
        peripheral_flow_ack <= 1'b0;
      end
      if (!reverse_ack && !host_ack_out && select_in_out && peripheral_ack_strobe) begin
        pdata_in <= rev_byte;
        peripheral_ack_strobe <= 1'b0;
      end else if (host_ack_out && !peripheral_ack_strobe) begin
        peripheral_ack_strobe <= 1'b1;
        pdata_in <= ~rev_byte;
      end
    end
  end
endmodule

// ---- dv/ecp_parallel_port_properties.sv ----
`timescale 1ns/1ps
module ecp_parallel_port_properties
  import ecp_port_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              aen,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [7:0]        pdata_out,
  input wire logic              pdata_oe_n,
  input wire logic              strobe_n,
  input wire logic              host_ack_out,
  input wire logic              direction_init_out,
  input wire logic              select_in_out,
  input wire logic              peripheral_ack_strobe,
  input wire logic              peripheral_flow_ack,
  input wire logic              reverse_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Mode tracking, base index assumed zero
  // ----
  logic [2:0] mode;
  logic       dirb, e1, e2, ecp_on, wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= MODE_STD;
      dirb <= 1'b0;
      e1 <= 1'b0;
      e2 <= 1'b0;
    end else begin
      if (wr_ok && paddr[13:2] == IDX_EXTCTRL) mode <= pwdata[7:5];
      if (wr_ok && paddr[13:2] == IDX_CONTROL) dirb <= pwdata[CTL_DIR];
      e1 <= (mode == MODE_ECP);
      e2 <= e1;
    end
  end
  assign ecp_on = e1 && e2 && (mode == MODE_ECP);
  sequence s_take;
    psel && penable && pready;
  endsequence
  property p_aen;
    s_take ##0 aen |-> pslverr && prdata == 32'h0;
  endproperty
  a_aen: assert property (p_aen) else $error("aen access not refused");
  property p_unmapped;
    s_take ##0 (paddr[13:2] == IDX_CONFIGB && mode != MODE_CONFIG) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("config b decoded outside mode");
  property p_reset;
    $fell(rst) |-> strobe_n && select_in_out && !direction_init_out && host_ack_out;
  endproperty
  a_reset: assert property (p_reset) else $error("bad line state after reset");
  property p_tag;
    ecp_on && !strobe_n && !$fell(strobe_n) |-> $stable(host_ack_out) && $stable(pdata_out);
  endproperty
  a_tag: assert property (p_tag) else $error("tag or byte moved under strobe");
  property p_release;
    ecp_on && !strobe_n && peripheral_flow_ack |-> ##[1:2] strobe_n;
  endproperty
  a_release: assert property (p_release) else $error("strobe not released");
  property p_rev;
    ecp_on && !direction_init_out && !host_ack_out && !peripheral_ack_strobe
      |-> ##[1:2] host_ack_out;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse byte not acknowledged");
  property p_bus_off;
    ecp_on && $rose(pdata_oe_n) |-> $past(reverse_ack) == 1'b0;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus freed before turn ack");
  property p_bus_on;
    ecp_on && $fell(pdata_oe_n) |-> $past(reverse_ack) == 1'b1;
  endproperty
  a_bus_on: assert property (p_bus_on) else $error("bus driven before forward ack");
  property p_selin;
    ecp_on |-> select_in_out;
  endproperty
  a_selin: assert property (p_selin) else $error("select in asserted in ecp");
  property p_dir;
    ecp_on && $fell(direction_init_out) |-> dirb;
  endproperty
  a_dir: assert property (p_dir) else $error("reverse without direction bit");
endmodule
bind ecp_parallel_port ecp_parallel_port_properties u_props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .aen(aen), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .pdata_out(pdata_out), .pdata_oe_n(pdata_oe_n), .strobe_n(strobe_n),
  .host_ack_out(host_ack_out), .direction_init_out(direction_init_out),
  .select_in_out(select_in_out), .peripheral_ack_strobe(peripheral_ack_strobe),
  .peripheral_flow_ack(peripheral_flow_ack), .reverse_ack(reverse_ack)
);

// ---- dv/ecp_parallel_port_tb_top.sv ----
`timescale 1ns/1ps
module ecp_parallel_port_tb_top;
  import ecp_port_pkg::*;
  logic              clk, rst, psel, penable, pwrite, aen, pready, pslverr, erv;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic [7:0]        pdata_in, pdata_out;
  logic              pdata_oe_n, strobe_n, host_ack_out, direction_init_out, select_in_out;
  logic              peripheral_ack_strobe, peripheral_flow_ack, reverse_ack, online_in;
  logic              fault_in;
  int                fails, n_checks;
  ecp_parallel_port uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .aen(aen), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pdata_in(pdata_in), .pdata_out(pdata_out), .pdata_oe_n(pdata_oe_n),
    .strobe_n(strobe_n), .host_ack_out(host_ack_out),
    .direction_init_out(direction_init_out), .select_in_out(select_in_out),
    .peripheral_ack_strobe(peripheral_ack_strobe), .peripheral_flow_ack(peripheral_flow_ack),
    .reverse_ack(reverse_ack), .online_in(online_in), .fault_in(fault_in));
  ecp_peripheral_model m (
    .clk(clk), .rst(rst), .pdata_out(pdata_out), .strobe_n(strobe_n),
    .host_ack_out(host_ack_out), .direction_init_out(direction_init_out),
    .select_in_out(select_in_out), .pdata_in(pdata_in),
    .peripheral_ack_strobe(peripheral_ack_strobe), .peripheral_flow_ack(peripheral_flow_ack),
    .reverse_ack(reverse_ack), .online_in(online_in), .fault_in(fault_in));
  // ----
  // Checks and bus cycles
  // ----
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    rdv = prdata;
    erv = pslverr;
    chk_bit(n < 20, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk_bit(erv, err);
    if (!err) chk_val(rdv, exp);
  endtask
  task automatic await(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 200) begin
      n++;
      @(posedge clk);
    end
    chk_bit(s, v);
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk_bit(strobe_n & select_in_out & host_ack_out, 1'b1);
    chk_bit(direction_init_out | pdata_oe_n, 1'b0);
    rd(14'h1008, 32'h01, 1'b0);
    rd(14'h1000, 32'h0, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_std();
    wr(14'h0000, 32'ha5);
    @(posedge clk);
    chk_val({24'h0, pdata_out}, 32'ha5);
    rd(14'h0000, 32'ha5, 1'b0);
    rd(14'h0004, {24'h0, ~peripheral_flow_ack, peripheral_ack_strobe, reverse_ack,
                  online_in, fault_in, 3'h0}, 1'b0);
    wr(14'h0008, 32'h0c);
    @(posedge clk);
    chk_bit(select_in_out | ~direction_init_out, 1'b0);
    wr(14'h0008, 32'h00);
    $display("test standard done");
  endtask
  task automatic t_modes();
    logic [7:0] fifo_ok, data_ok;
    fifo_ok = 8'hcc;
    data_ok = 8'h0b;
    wr(14'h3fc0, 32'h1000);
    for (int i = 0; i < 8; i++) begin
      if (i != 5) begin
        wr(14'h1008, 32'(i) << 5);
        rd(14'h1008, (32'(i) << 5) | 32'h1, 1'b0);
        apb(1'b0, 14'h1000, 32'h0);
        chk_bit(erv, !fifo_ok[i]);
        apb(1'b0, 14'h0000, 32'h0);
        chk_bit(erv, !data_ok[i]);
        rd(14'h1004, 32'h0, i != 7);
        apb(1'b0, 14'h0004, 32'h0);
        chk_bit(erv, 1'b0);
      end
    end
    wr(14'h1000, 32'hff);
    rd(14'h1000, 32'h10, 1'b0);
    wr(14'h3fc0, 32'h0000);
    wr(14'h1008, 32'h80);
    rd(14'h0000, 32'ha5, 1'b0);
    wr(14'h1008, 32'h00);
    aen <= 1'b1;
    wr(14'h1008, 32'h60);
    rd(14'h1008, 32'h0, 1'b1);
    chk_val(rdv, 32'h0);
    aen <= 1'b0;
    rd(14'h1008, 32'h01, 1'b0);
    wr(14'h3fc0, 32'h0010);
    rd(14'h1048, 32'h01, 1'b0);
    rd(14'h1008, 32'h0, 1'b1);
    wr(14'h3fc0, 32'h0000);
    $display("test modes done");
  endtask
  task automatic t_fwd();
    logic [13:0] a[2];
    logic [7:0]  b[2];
    a = '{14'h1000, 14'h0000};
    b = '{8'h3c, 8'h5a};
    wr(14'h1008, 32'h60);
    @(posedge clk);
    chk_bit(select_in_out & direction_init_out, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(a[i], {24'h0, b[i]});
      await(peripheral_flow_ack, 1'b1);
      chk_val({24'h0, m.got}, {24'h0, b[i]});
      chk_bit(m.tag, i == 0);
      await(peripheral_flow_ack, 1'b0);
    end
    wr(14'h1008, 32'h40);
    wr(14'h1000, 32'h77);
    await(peripheral_flow_ack, 1'b1);
    chk_val({24'h0, m.got}, 32'h77);
    await(peripheral_flow_ack, 1'b0);
    rd(14'h1008, 32'h41, 1'b0);
    $display("test forward done");
  endtask
  task automatic t_fault();
    wr(14'h1008, 32'h60);
    m.fault_in <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, 14'h3fc0, 32'h0);
    chk_bit(rdv[SET_PREQ], 1'b1);
    chk_bit(direction_init_out, 1'b1);
    m.fault_in <= 1'b1;
    wr(14'h3fc0, 32'h2000);
    apb(1'b0, 14'h3fc0, 32'h0);
    chk_bit(rdv[SET_PREQ], 1'b0);
    $display("test request done");
  endtask
  task automatic t_rev();
    m.rev_byte <= 8'hc3;
    wr(14'h0008, 32'h20);
    await(direction_init_out, 1'b0);
    await(pdata_oe_n, 1'b1);
    await(peripheral_ack_strobe, 1'b0);
    await(host_ack_out, 1'b1);
    m.fault_in <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, 14'h3fc0, 32'h0);
    chk_bit(rdv[SET_PREQ], 1'b0);
    m.fault_in <= 1'b1;
    rd(14'h1000, 32'hc3, 1'b0);
    wr(14'h0008, 32'h00);
    await(direction_init_out, 1'b1);
    await(pdata_oe_n, 1'b0);
    wr(14'h1008, 32'h00);
    $display("test reverse done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    aen = 1'b0;
    fails = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_std();
    t_modes();
    t_fwd();
    t_fault();
    t_rev();
    wrap_up();
  end
endmodule
